// ---- core/prs_pkg.sv ----
// Constants for the packed right shift unit: instruction fields, opcodes, result kinds.
// Assumes a 32-bit instruction word in the usual six-field layout.
package prs_pkg;
    // ==========================================
    // Instruction field positions
    localparam int MAJOR_HI     = 31;
    localparam int MAJOR_LO     = 26;
    localparam int SRC_HI       = 25;
    localparam int SRC_LO       = 21;
    localparam int OPND_HI      = 20;
    localparam int OPND_LO      = 16;
    localparam int DEST_HI      = 15;
    localparam int DEST_LO      = 11;
    localparam int SUBOP_HI     = 10;
    localparam int SUBOP_LO     = 6;
    localparam int FUNC_HI      = 5;
    localparam int FUNC_LO      = 0;
    localparam int PH_IMM_ZERO  = 25;
    localparam int PH_IMM_HI    = 24;
    localparam int PH_IMM_LO    = 21;
    localparam int QB_IMM_HI    = 23;
    localparam int QB_IMM_LO    = 21;
    // ==========================================
    // Opcodes
    localparam logic [5:0] OP_EXTENDED_MAJOR = 6'h1F;
    localparam logic [5:0] FN_SHIFT_GROUP    = 6'h13;
    localparam logic [4:0] SUB_ARITH_VAR_RND = 5'h17;
    localparam logic [4:0] SUB_PAIR_IMM      = 5'h19;
    localparam logic [4:0] SUB_PAIR_VAR      = 5'h1B;
    localparam logic [4:0] SUB_QUAD_VAR      = 5'h03;
    localparam logic [4:0] SUB_QUAD_IMM      = 5'h01;
    // ==========================================
    // Result selection
    typedef enum logic [2:0] {
        PRS_NONE      = 3'b000,
        PRS_WORD_RND  = 3'b001,
        PRS_PAIR      = 3'b010,
        PRS_QUAD      = 3'b011
    } prs_kind_type;
endpackage : prs_pkg

// ---- core/prs_shift_unit.sv ----
// Packed right shift unit: one-cycle datapath for five right-shift instructions.
// Assumes the pipeline presents a decoded instruction word and both operands with a valid strobe.
//
// Function
// - The rounding word shift replicates the operand sign into vacated upper bits.
// - The rounding word shift adds one at the highest discarded bit before writeback.
// - The rounding word shift count is the low five bits of the count source.
// - The rounding word shift builds a 33-bit value, adds one and returns bits 32 to 1.
// - The immediate pair shift is sub-op 11001 with bit 25 zero and count in bits 24 to 21.
// - The pair shifts move each 16-bit lane right by 0 to 15 with zero fill.
// - The quad shifts move each byte right by a three-bit count with zero fill.
// - The variable pair shift is sub-op 11011 and uses the low four count-source bits.
// - The variable quad shift is sub-op 00011 and uses the low three count-source bits.
// - No exception ever depends on operand values or shift counts.
// - Reserved or extension-disabled conditions raise their exception instead of executing.
`timescale 1ns/1ns
module prs_shift_unit (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_valid,
    input  wire logic [31:0] i_instr,
    input  wire logic [31:0] i_shift_count_source,
    input  wire logic [31:0] i_operand_source,
    input  wire logic        i_ext_enable,
    output logic             o_wr_en,
    output logic [4:0]       o_wr_addr,
    output logic [31:0]      o_wr_data,
    output logic             o_reserved_exc,
    output logic             o_ext_disabled_exc
);
    // ==========================================
    // Decode
    logic                  is_group;
    logic [4:0]            subop;
    prs_pkg::prs_kind_type kind;
    logic [4:0]            count;
    logic                  matched;

    always_comb begin
        is_group = (i_instr[prs_pkg::MAJOR_HI:prs_pkg::MAJOR_LO] == prs_pkg::OP_EXTENDED_MAJOR)
                && (i_instr[prs_pkg::FUNC_HI:prs_pkg::FUNC_LO] == prs_pkg::FN_SHIFT_GROUP);
        subop = i_instr[prs_pkg::SUBOP_HI:prs_pkg::SUBOP_LO];
        kind = prs_pkg::PRS_NONE;
        count = 5'h0;
        if (subop == prs_pkg::SUB_ARITH_VAR_RND) begin
            kind = prs_pkg::PRS_WORD_RND;
            count = i_shift_count_source[4:0];
        end else if (subop == prs_pkg::SUB_PAIR_IMM && !i_instr[prs_pkg::PH_IMM_ZERO]) begin
            kind = prs_pkg::PRS_PAIR;
            count = {1'b0, i_instr[prs_pkg::PH_IMM_HI:prs_pkg::PH_IMM_LO]};
        end else if (subop == prs_pkg::SUB_PAIR_VAR) begin
            kind = prs_pkg::PRS_PAIR;
            count = {1'b0, i_shift_count_source[3:0]};
        end else if (subop == prs_pkg::SUB_QUAD_VAR) begin
            kind = prs_pkg::PRS_QUAD;
            count = {2'b00, i_shift_count_source[2:0]};
        end else if (subop == prs_pkg::SUB_QUAD_IMM) begin
            kind = prs_pkg::PRS_QUAD;
            count = {2'b00, i_instr[prs_pkg::QB_IMM_HI:prs_pkg::QB_IMM_LO]};
        end
        matched = is_group && (kind != prs_pkg::PRS_NONE);
    end

    // ==========================================
    // Datapath
    logic [32:0] word_pre;
    logic [32:0] word_sum;
    logic [31:0] pair_res;
    logic [31:0] quad_res;
    logic [31:0] result;

    always_comb begin
        // Shifting the 33-bit extended value by count-1 keeps one discarded bit for rounding.
        if (count == 5'h0) begin
            word_pre = {i_operand_source, 1'b0};
        end else begin
            word_pre = 33'($signed({i_operand_source[31], i_operand_source})
                           >>> (count - 5'h1));
        end
        word_sum = word_pre + 33'h0_0000_0001;
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pair
            assign pair_res[16*g +: 16] = i_operand_source[16*g +: 16] >> count[3:0];
        end
        for (g = 0; g < 4; g++) begin : g_quad
            assign quad_res[8*g +: 8] = i_operand_source[8*g +: 8] >> count[2:0];
        end
    endgenerate

    always_comb begin
        case (kind)
            prs_pkg::PRS_WORD_RND: result = word_sum[32:1];
            prs_pkg::PRS_PAIR:     result = pair_res;
            prs_pkg::PRS_QUAD:     result = quad_res;
            default:               result = 32'h0000_0000;
        endcase
    end

    // ==========================================
    // Writeback and exceptions
    logic        wr_en_reg, wr_en_next;
    logic [4:0]  wr_addr_reg, wr_addr_next;
    logic [31:0] wr_data_reg, wr_data_next;
    logic        rsv_reg, rsv_next;
    logic        dis_reg, dis_next;

    always_comb begin
        // Exceptions look only at the encoding and enable, never at operand data.
        dis_next = i_valid && matched && !i_ext_enable;
        rsv_next = i_valid && is_group && !matched;
        wr_en_next = i_valid && matched && i_ext_enable;
        wr_addr_next = wr_en_next ? i_instr[prs_pkg::DEST_HI:prs_pkg::DEST_LO] : wr_addr_reg;
        wr_data_next = wr_en_next ? result : wr_data_reg;
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_en_reg   <= 1'b0;
            wr_addr_reg <= 5'h0;
            wr_data_reg <= 32'h0000_0000;
            rsv_reg     <= 1'b0;
            dis_reg     <= 1'b0;
        end else begin
            wr_en_reg   <= wr_en_next;
            wr_addr_reg <= wr_addr_next;
            wr_data_reg <= wr_data_next;
            rsv_reg     <= rsv_next;
            dis_reg     <= dis_next;
        end
    end

    assign o_wr_en            = wr_en_reg;
    assign o_wr_addr          = wr_addr_reg;
    assign o_wr_data          = wr_data_reg;
    assign o_reserved_exc     = rsv_reg;
    assign o_ext_disabled_exc = dis_reg;

    // ==========================================
    // Assertions
    // The rounding check is rebuilt as truncate-then-round, a different route from the datapath,
    // so that a slip in the 33-bit trick cannot hide behind an identical copy of itself.
    logic [31:0] chk_trunc;
    logic        chk_rbit;
    logic [3:0]  chk_pair_imm;
    logic [2:0]  chk_quad_imm;

    always_comb begin
        chk_trunc = 32'($signed(i_operand_source) >>> i_shift_count_source[4:0]);
        chk_rbit = i_operand_source[i_shift_count_source[4:0] - 5'h1];
        chk_pair_imm = i_instr[prs_pkg::PH_IMM_HI:prs_pkg::PH_IMM_LO];
        chk_quad_imm = i_instr[prs_pkg::QB_IMM_HI:prs_pkg::QB_IMM_LO];
    end

    sequence s_round_req;
        i_valid && i_ext_enable && is_group && subop == prs_pkg::SUB_ARITH_VAR_RND
        && i_shift_count_source[4:0] != 5'h0;
    endsequence

    property p_round;
        @(posedge i_core_clk) disable iff (i_rst)
        s_round_req |=> o_wr_data == $past(chk_trunc) + 32'($past(chk_rbit));
    endproperty
    a_round: assert property (p_round) else $error("rounding bit not added");

    property p_excl;
        @(posedge i_core_clk) disable iff (i_rst)
        !(o_wr_en && (o_reserved_exc || o_ext_disabled_exc));
    endproperty
    a_excl: assert property (p_excl) else $error("write with exception");

    property p_word;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_valid && i_ext_enable && is_group && subop == prs_pkg::SUB_ARITH_VAR_RND
         && i_shift_count_source[4:0] == 5'h0) |=> o_wr_data == $past(i_operand_source);
    endproperty
    a_word: assert property (p_word) else $error("zero count word shift wrong");

    property p_sign;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_valid && i_ext_enable && is_group && subop == prs_pkg::SUB_ARITH_VAR_RND
         && i_shift_count_source[4:0] == 5'd31)
        |=> o_wr_data == {32{$past(i_operand_source[31])}} + 32'($past(i_operand_source[30]));
    endproperty
    a_sign: assert property (p_sign) else $error("sign fill wrong");

    property p_pair;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_valid && i_ext_enable && is_group && subop == prs_pkg::SUB_PAIR_VAR)
        |=> o_wr_data[31:16]
            == ($past(i_operand_source[31:16]) >> $past(i_shift_count_source[3:0]));
    endproperty
    a_pair: assert property (p_pair) else $error("pair shift wrong");

    property p_quad;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_valid && i_ext_enable && is_group && subop == prs_pkg::SUB_QUAD_VAR)
        |=> o_wr_data[7:0] == ($past(i_operand_source[7:0]) >> $past(i_shift_count_source[2:0]));
    endproperty
    a_quad: assert property (p_quad) else $error("quad shift wrong");

    property p_disabled;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_valid && matched && !i_ext_enable) |=> o_ext_disabled_exc && !o_wr_en;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disable exception missing");

    property p_nodata;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_valid && matched && i_ext_enable) |=> o_wr_en && !o_reserved_exc;
    endproperty
    a_nodata: assert property (p_nodata) else $error("data dependent exception");

    property p_imm;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_valid && i_ext_enable && is_group && subop == prs_pkg::SUB_PAIR_IMM
         && !i_instr[prs_pkg::PH_IMM_ZERO])
        |=> o_wr_data[15:0] == ($past(i_operand_source[15:0]) >> $past(chk_pair_imm));
    endproperty
    a_imm: assert property (p_imm) else $error("immediate pair shift wrong");

    property p_quad_imm;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_valid && i_ext_enable && is_group && subop == prs_pkg::SUB_QUAD_IMM)
        |=> o_wr_data[31:24] == ($past(i_operand_source[31:24]) >> $past(chk_quad_imm));
    endproperty
    a_quad_imm: assert property (p_quad_imm) else $error("immediate quad shift wrong");

    property p_reserved;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_valid && is_group && !matched) |=> o_reserved_exc && !o_wr_en;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved exception missing");
endmodule : prs_shift_unit

// ---- bench/prs_pipe_model.sv ----
// Pipeline-side model that presents one instruction and its operands per call.
// Assumes the caller shares the core clock with the shift unit.
`timescale 1ns/1ns
module prs_pipe_model (
    input  wire logic        i_core_clk,
    output logic             o_valid,
    output logic [31:0]      o_instr,
    output logic [31:0]      o_count,
    output logic [31:0]      o_operand,
    output logic             o_ext_enable
);
    // ==========================================
    // Request driver
    initial begin
        {o_valid, o_instr, o_count, o_operand, o_ext_enable} = '0;
    end
    // Operands are handed over already packed as the instruction expects.
    task automatic issue(input logic v, input logic [31:0] ins, input logic [31:0] c,
                         input logic [31:0] op, input logic en);
        @(posedge i_core_clk);
        #5;
        {o_valid, o_instr, o_count, o_operand, o_ext_enable} = {v, ins, c, op, en};
    endtask : issue
    // Idle lines toggle so a stale value is never mistaken for a live one.
    task automatic idle();
        issue(1'b0, ~o_instr, ~o_count, ~o_operand, ~o_ext_enable);
    endtask : idle
endmodule : prs_pipe_model

// ---- bench/tb.sv ----
// Self-checking bench for the packed right shift unit with a reference model.
// Assumes prs_pkg and prs_shift_unit are compiled first.
`timescale 1ns/1ns
module tb;
    logic        i_core_clk = 1'b0;
    logic        i_rst      = 1'b1;
    logic        valid, ext, wr_en, rsv, dis, pend = 1'b0;
    logic [31:0] instr, cnt, opnd, wr_data, e_data;
    logic [4:0]  wr_addr, e_addr;
    logic [2:0]  e_flags;
    int          fail_count = 0;
    int          n_tests    = 0;
    always #25 i_core_clk = ~i_core_clk;
    prs_pipe_model PM (.i_core_clk(i_core_clk), .o_valid(valid), .o_instr(instr),
        .o_count(cnt), .o_operand(opnd), .o_ext_enable(ext));
    prs_shift_unit DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_valid(valid),
        .i_instr(instr), .i_shift_count_source(cnt), .i_operand_source(opnd),
        .i_ext_enable(ext), .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
        .o_reserved_exc(rsv), .o_ext_disabled_exc(dis));
    // ==========================================
    // Reference model
    function automatic logic [31:0] mdl(logic [31:0] ins, logic [31:0] c, logic [31:0] op);
        longint w;
        int n;
        logic [31:0] r = '0;
        case (ins[10:6])
            prs_pkg::SUB_ARITH_VAR_RND: begin
                w = ((longint'($signed(op)) <<< 1) >>> c[4:0]) + 1;
                r = w[32:1];
            end
            prs_pkg::SUB_PAIR_IMM, prs_pkg::SUB_PAIR_VAR: begin
                n = (ins[10:6] == prs_pkg::SUB_PAIR_IMM) ? ins[24:21] : c[3:0];
                r = {op[31:16] >> n, op[15:0] >> n};
            end
            prs_pkg::SUB_QUAD_IMM, prs_pkg::SUB_QUAD_VAR: begin
                n = (ins[10:6] == prs_pkg::SUB_QUAD_IMM) ? ins[23:21] : c[2:0];
                for (int b = 0; b < 4; b++) r[8*b+:8] = op[8*b+:8] >> n;
            end
            default: r = '0;
        endcase
        return r;
    endfunction : mdl
    task automatic send(logic [31:0] ins, logic [31:0] c, logic [31:0] op, logic en);
        logic grp, known;
        PM.issue(1'b1, ins, c, op, en);
        grp = ins[31:26] == prs_pkg::OP_EXTENDED_MAJOR && ins[5:0] == prs_pkg::FN_SHIFT_GROUP;
        known = ins[10:6] inside {prs_pkg::SUB_ARITH_VAR_RND, prs_pkg::SUB_PAIR_IMM,
            prs_pkg::SUB_PAIR_VAR, prs_pkg::SUB_QUAD_VAR, prs_pkg::SUB_QUAD_IMM}
            && !(ins[10:6] == prs_pkg::SUB_PAIR_IMM && ins[25]);
        e_flags = !grp ? 3'b000 : !known ? 3'b010 : en ? 3'b100 : 3'b001;
        {e_addr, e_data} = {ins[15:11], mdl(ins, c, op)};
        pend = 1'b1;
    endtask : send
    // ==========================================
    // Result checker, one cycle after each request
    always @(posedge i_core_clk) begin
        #2;
        n_tests++;
        if ({wr_en, rsv, dis} !== (pend ? e_flags : 3'b000)
            || (pend && e_flags[2] && {wr_addr, wr_data} !== {e_addr, e_data})) begin
            fail_count++;
            $display("ERROR t=%0t got %h exp %h", $time, {wr_en, rsv, dis, wr_addr, wr_data},
                     {pend ? e_flags : 3'b000, e_addr, e_data});
        end
        pend = 1'b0;
    end
    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
    // ==========================================
    // Stimulus: zero and full counts first, then random, back to back
    initial begin
        logic [31:0] c, op, ins;
        logic [4:0] subs [5];
        subs = '{prs_pkg::SUB_ARITH_VAR_RND, prs_pkg::SUB_PAIR_IMM, prs_pkg::SUB_PAIR_VAR,
                 prs_pkg::SUB_QUAD_VAR, prs_pkg::SUB_QUAD_IMM};
        void'($urandom(42));
        repeat (2) @(posedge i_core_clk);
        #5 i_rst = 1'b0;
        for (int i = 0; i < 305; i++) begin
            c = (i < 5) ? 32'h0000_0000 : (i < 10) ? 32'hFFFF_FFFF : $urandom;
            op = $urandom;
            ins = $urandom;
            ins[31:26] = prs_pkg::OP_EXTENDED_MAJOR;
            ins[25:21] = c[4:0];
            ins[5:0] = prs_pkg::FN_SHIFT_GROUP;
            ins[10:6] = (i < 300) ? subs[i % 5] : subs[i - 300];
            if (ins[10:6] == prs_pkg::SUB_PAIR_IMM) ins[25] = 1'b0;
            if (i < 300) begin
                send(ins, c, op, 1'b1);
            end else begin
                send(ins, c, op, 1'b0);
            end
        end
        ins[10:6] = 5'h1F;
        send(ins, c, op, 1'b1);
        {ins[25], ins[10:6]} = {1'b1, prs_pkg::SUB_PAIR_IMM};
        send(ins, c, op, 1'b1);
        ins[5:0] = 6'h00;
        send(ins, c, op, 1'b1);
        PM.idle();
        // A second reset in mid-run must clear the held destination and accept work again.
        i_rst = 1'b1;
        repeat (2) @(posedge i_core_clk);
        #5 i_rst = 1'b0;
        n_tests++;
        if ({wr_addr, wr_data} !== '0) begin
            fail_count++;
            $display("ERROR t=%0t got %h exp %h", $time, {wr_addr, wr_data}, 37'h0);
        end
        ins[5:0] = prs_pkg::FN_SHIFT_GROUP;
        ins[10:6] = prs_pkg::SUB_ARITH_VAR_RND;
        send(ins, c, op, 1'b1);
        PM.idle();
        repeat (3) @(posedge i_core_clk);
        give_verdict();
    end
endmodule : tb
